// >>> hw/charger_detect_port_power.sv
// charger detection, port role assignment and port power control
`timescale 1ns/1ps
module charger_detect_port_power
   import chg_pkg::*;
#(
   parameter int NPORTS    = NUM_PORTS,
   parameter int SHORT_CYC = SHORT_OFF_CYC,
   parameter int LONG_CYC  = LONG_OFF_CYC
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   input  wire logic              ce_i,
   // startup sense and straps
   input  wire logic              slave_serial_data_pin_i,
   input  wire logic              slave_serial_clock_pin_i,
   input  wire logic [NPORTS-1:0] charge_enable_strap_i,
   input  wire logic              detect_enable_i,
   input  wire logic              enhanced_detect_setting_i,
   input  wire logic              osc_detect_enable_i,
   // startup sequencer stages
   input  wire logic              reference_clock_wait_stage_i,
   input  wire logic              charger_detect_stage_i,
   input  wire logic              init_done_i,
   input  wire logic              host_connected_i,
   // analog line profile
   input  wire logic [2:0]        line_profile_i,
   // configuration sources
   input  wire logic              usb_cfg_we_i,
   input  wire logic [7:0]        usb_cfg_data_i,
   input  wire logic              otp_cfg_valid_i,
   input  wire logic [7:0]        otp_cfg_data_i,
   // register access from the serial slave
   input  wire logic              reg_we_i,
   input  wire logic              reg_re_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   output logic [7:0]             reg_rdata_o,
   output logic                   slave_enable_o,
   output logic                   otp_prog_we_o,
   output logic [7:0]             otp_prog_data_o,
   // custom detection controls
   output logic [7:0]             custom_ctrl_o,
   // port power and over-current
   input  wire logic              ganged_mode_i,
   input  wire logic [NPORTS-1:0] host_port_power_i,
   input  wire logic [NPORTS-1:0] overcurrent_sense_i,
   output logic [NPORTS-1:0]      port_power_output_o,
   output logic [2*NPORTS-1:0]    port_role_o,
   output logic [NPORTS-1:0]      charge_ack_o,
   // detection result
   output logic [2:0]             charger_type_o,
   output logic                   charger_irq_o
);
   typedef enum logic [1:0] {
      DET_IDLE   = 2'b00,
      DET_SETTLE = 2'b01,
      DET_DONE   = 2'b10
   } det_state_t;

   det_state_t        det_ff;
   logic [4:0]        settle_ff;
   logic [2:0]        type_ff;
   logic              irq_ff;
   logic              started_ff;
   logic              sense_ff;
   logic              slave_en_ff;
   logic [7:0]        chg_en_ff;
   logic [7:0]        custom_ff;
   logic              frozen_ff;
   logic [NPORTS-1:0] dcp_ff;
   logic [NPORTS-1:0] chg_ff;
   logic [NPORTS-1:0] pwr_raw;
   logic [NPORTS-1:0] fault;
   logic [7:0]        rdata_ff;
   logic              start_det;

   function automatic logic [2:0] classify(input logic [2:0] prof, input logic enh);
      case (prof)
         PROF_SHORTED:  classify = TYPE_DCP;
         PROF_REFLECT:  classify = enh ? TYPE_CDP : TYPE_SDP;
         PROF_PULLDOWN: classify = TYPE_SDP;
         PROF_P20_M20:  classify = TYPE_PROP_LOW;
         PROF_P20_M27:  classify = TYPE_PROP_HIGH;
         PROF_P27_M20:  classify = TYPE_PROP_SUPER;
         default:       classify = TYPE_NONE;
      endcase
   endfunction : classify

   // serial slave enable sampled once after reset release
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sense_ff    <= 1'b0;
         slave_en_ff <= 1'b0;
      end else if (ce_i && !sense_ff) begin
         sense_ff    <= 1'b1;
         slave_en_ff <= slave_serial_data_pin_i && slave_serial_clock_pin_i;
      end
   end

   assign start_det = !started_ff && detect_enable_i &&
                      (charger_detect_stage_i ||
                       (reference_clock_wait_stage_i && osc_detect_enable_i));

   // detection sequencer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         det_ff     <= DET_IDLE;
         settle_ff  <= 5'h0;
         type_ff    <= TYPE_NONE;
         started_ff <= 1'b0;
      end else if (ce_i) begin
         case (det_ff)
            DET_IDLE: begin
               if (start_det) begin
                  started_ff <= 1'b1;
                  settle_ff  <= 5'(DET_SETTLE_CYC - 1);
                  det_ff     <= DET_SETTLE;
               end
            end
            DET_SETTLE: begin
               if (settle_ff == 5'h0) begin
                  type_ff <= classify(line_profile_i, enhanced_detect_setting_i);
                  det_ff  <= DET_DONE;
               end else begin
                  settle_ff <= settle_ff - 5'h1;
               end
            end
            DET_DONE: det_ff <= DET_DONE;
            default:  det_ff <= DET_IDLE;
         endcase
      end
   end

   // interrupt: set on completion, cleared by status read; set wins
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_ff <= 1'b0;
      end else if (ce_i) begin
         if (det_ff == DET_SETTLE && settle_ff == 5'h0) begin
            irq_ff <= 1'b1;
         end else if (reg_re_i && slave_en_ff && reg_addr_i == REG_CHG_STATUS) begin
            irq_ff <= 1'b0;
         end
      end
   end

   // custom control writable in any stage; charging enable register writable only until roles are frozen
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         chg_en_ff <= CHG_EN_RESET;
         custom_ff <= 8'h00;
      end else if (ce_i) begin
         if (reg_we_i && slave_en_ff && reg_addr_i == REG_CUSTOM_CTRL) begin
            custom_ff <= reg_wdata_i;
         end
         if (!frozen_ff) begin
            if (reg_we_i && slave_en_ff && reg_addr_i == REG_CHG_EN) begin
               chg_en_ff <= reg_wdata_i;
            end else if (usb_cfg_we_i) begin
               chg_en_ff <= usb_cfg_data_i;
            end else if (otp_cfg_valid_i) begin
               chg_en_ff <= otp_cfg_data_i;
            end else if (!sense_ff) begin
               chg_en_ff <= 8'(charge_enable_strap_i) << CHG_EN_LSB;
            end
         end
      end
   end

   // roles frozen when initialization completes
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         frozen_ff <= 1'b0;
         chg_ff    <= '0;
         dcp_ff    <= '0;
      end else if (ce_i) begin
         if (!frozen_ff && init_done_i) begin
            frozen_ff <= 1'b1;
            chg_ff    <= chg_en_ff[CHG_EN_LSB +: NPORTS];
            dcp_ff    <= chg_en_ff[CHG_EN_LSB +: NPORTS] & {NPORTS{!host_connected_i}};
         end
      end
   end

   // ganged mode spreads any fault to every port
   assign fault = ganged_mode_i ? {NPORTS{|overcurrent_sense_i}} : overcurrent_sense_i;

   for (genvar p = 0; p < NPORTS; p++) begin : g_port
      port_power_ctrl #(
         .SHORT_CYC (SHORT_CYC),
         .LONG_CYC  (LONG_CYC)
      ) u_pwr (
         .clk_i      (clk_i),
         .srst_i     (srst_i),
         .ce_i       (ce_i),
         .active_i   (frozen_ff && chg_ff[p]),
         .dcp_i      (dcp_ff[p]),
         .host_pwr_i (host_port_power_i[p] && !fault[p]),
         .fault_i    (fault[p]),
         .pwr_o      (pwr_raw[p]),
         .retries_o  ()
      );
      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            port_power_output_o[p] <= 1'b0;
         end else if (ce_i) begin
            port_power_output_o[p] <= chg_ff[p] ? pwr_raw[p]
                                     : (frozen_ff && host_port_power_i[p] && !fault[p]);
         end
      end
      assign port_role_o[2*p +: 2] = !frozen_ff ? ROLE_SDP :
                                     (dcp_ff[p] ? ROLE_DCP :
                                     (chg_ff[p] ? ROLE_CDP : ROLE_SDP));
      assign charge_ack_o[p] = frozen_ff && chg_ff[p];
   end

   // read data register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_ff <= 8'h00;
      end else if (ce_i && reg_re_i && slave_en_ff) begin
         case (reg_addr_i)
            REG_CHG_EN:      rdata_ff <= chg_en_ff;
            REG_CHG_STATUS:  rdata_ff <= {4'h0, irq_ff, type_ff};
            REG_CUSTOM_CTRL: rdata_ff <= custom_ff;
            REG_PORT_STATUS: rdata_ff <= 8'(port_power_output_o) | (8'(frozen_ff) << 7);
            default:         rdata_ff <= 8'h00;
         endcase
      end
   end

   assign otp_prog_we_o   = ce_i && reg_we_i && slave_en_ff && reg_addr_i == REG_OTP_DATA;
   assign otp_prog_data_o = reg_wdata_i;
   assign reg_rdata_o     = rdata_ff;
   assign slave_enable_o  = slave_en_ff;
   assign custom_ctrl_o   = custom_ff;
   assign charger_type_o  = type_ff;
   assign charger_irq_o   = irq_ff;
endmodule : charger_detect_port_power

// >>> hw/chg_pkg.sv
// package with constants for the charger detect and port power block
package chg_pkg;
   localparam int          CLK_HZ           = 20_000_000;
   localparam int          NUM_PORTS        = 3;
   localparam logic [7:0]  REG_CHG_EN       = 8'h00;
   localparam logic [7:0]  REG_CHG_STATUS   = 8'h01;
   localparam logic [7:0]  REG_CUSTOM_CTRL  = 8'h02;
   localparam logic [7:0]  REG_PORT_STATUS  = 8'h03;
   localparam logic [7:0]  REG_OTP_DATA     = 8'h04;
   localparam logic [7:0]  CHG_EN_RESET     = 8'h00;
   localparam int          CHG_EN_LSB       = 1;
   localparam int          SHORT_OFF_MS     = 1000;
   localparam int          LONG_OFF_MS      = 10000;
   localparam int          SHORT_OFF_CYC    = SHORT_OFF_MS * (CLK_HZ / 1000);
   localparam int          LONG_OFF_CYC     = LONG_OFF_MS * (CLK_HZ / 1000);
   localparam int          SHORT_RETRIES    = 3;
   localparam logic [2:0]  TYPE_NONE        = 3'h0;
   localparam logic [2:0]  TYPE_DCP         = 3'h1;
   localparam logic [2:0]  TYPE_CDP         = 3'h2;
   localparam logic [2:0]  TYPE_SDP         = 3'h3;
   localparam logic [2:0]  TYPE_PROP_LOW    = 3'h4;
   localparam logic [2:0]  TYPE_PROP_HIGH   = 3'h5;
   localparam logic [2:0]  TYPE_PROP_SUPER  = 3'h6;
   // line profile codes from the analog comparators
   localparam logic [2:0]  PROF_OPEN        = 3'h0;
   localparam logic [2:0]  PROF_SHORTED     = 3'h1;
   localparam logic [2:0]  PROF_REFLECT     = 3'h2;
   localparam logic [2:0]  PROF_PULLDOWN    = 3'h3;
   localparam logic [2:0]  PROF_P20_M20     = 3'h4;
   localparam logic [2:0]  PROF_P20_M27     = 3'h5;
   localparam logic [2:0]  PROF_P27_M20     = 3'h6;
   localparam int          DET_SETTLE_CYC   = 16;

   typedef enum logic [1:0] {
      ROLE_SDP = 2'b00,
      ROLE_CDP = 2'b01,
      ROLE_DCP = 2'b10
   } port_role_t;
endpackage : chg_pkg

// >>> hw/port_power_ctrl.sv
// per-port over-current retry timer for one downstream port
`timescale 1ns/1ps
module port_power_ctrl
   import chg_pkg::*;
#(
   parameter int SHORT_CYC = SHORT_OFF_CYC,
   parameter int LONG_CYC  = LONG_OFF_CYC
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       ce_i,
   // control
   input  wire logic       active_i,
   input  wire logic       dcp_i,
   input  wire logic       host_pwr_i,
   input  wire logic       fault_i,
   // status
   output logic            pwr_o,
   output logic [1:0]      retries_o
);
   logic [31:0] timer_ff;
   logic [1:0]  retry_ff;
   logic        off_ff;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         timer_ff <= 32'h0;
         retry_ff <= 2'h0;
         off_ff   <= 1'b0;
      end else if (ce_i) begin
         if (!active_i || !dcp_i) begin
            off_ff   <= 1'b0;
            retry_ff <= 2'h0;
            timer_ff <= 32'h0;
         end else if (off_ff) begin
            if (timer_ff == 32'h0) begin
               off_ff <= 1'b0;
            end else begin
               timer_ff <= timer_ff - 32'h1;
            end
         end else if (fault_i) begin
            off_ff <= 1'b1;
            if (retry_ff < 2'(SHORT_RETRIES)) begin
               timer_ff <= 32'(SHORT_CYC - 1);
               retry_ff <= retry_ff + 2'h1;
            end else begin
               timer_ff <= 32'(LONG_CYC - 1);
            end
         end else begin
            retry_ff <= 2'h0;
         end
      end
   end

   // dcp ports self-manage, others follow the host setting
   assign pwr_o     = active_i && (dcp_i ? !off_ff : host_pwr_i);
   assign retries_o = retry_ff;
endmodule : port_power_ctrl

// >>> sim/cdpp_monitor.sv
// checker for charger detection and port power behaviour
`timescale 1ns/1ps
module cdpp_monitor
   import chg_pkg::*;
#(
   parameter int NPORTS    = NUM_PORTS,
   parameter int SHORT_CYC = SHORT_OFF_CYC,
   parameter int LONG_CYC  = LONG_OFF_CYC
) (
   // clock, reset and register access
   input wire logic                clk_i,
   input wire logic                srst_i,
   input wire logic                ce_i,
   input wire logic                reg_we_i,
   input wire logic                reg_re_i,
   input wire logic [7:0]          reg_addr_i,
   input wire logic [7:0]          reg_wdata_i,
   input wire logic                slave_enable_o,
   input wire logic [7:0]          custom_ctrl_o,
   // detection and ports
   input wire logic                enhanced_detect_setting_i,
   input wire logic [2:0]          charger_type_o,
   input wire logic                charger_irq_o,
   input wire logic                init_done_i,
   input wire logic                ganged_mode_i,
   input wire logic [NPORTS-1:0]   host_port_power_i,
   input wire logic [NPORTS-1:0]   overcurrent_sense_i,
   input wire logic [NPORTS-1:0]   port_power_output_o,
   input wire logic [2*NPORTS-1:0] port_role_o,
   input wire logic [NPORTS-1:0]   charge_ack_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);

   AST_CUSTOM_WR: assert property (
      ce_i && slave_enable_o && reg_we_i && reg_addr_i == REG_CUSTOM_CTRL
      |=> custom_ctrl_o == $past(reg_wdata_i)) else $error("custom write lost");
   AST_IRQ_HOLD: assert property (
      $fell(charger_irq_o) && !$past(srst_i) |-> $past(reg_re_i) && $past(ce_i)
      && $past(slave_enable_o) && $past(reg_addr_i) == REG_CHG_STATUS)
      else $error("irq dropped without status read");
   AST_CDP_ENH: assert property (
      charger_type_o == TYPE_CDP |-> enhanced_detect_setting_i) else $error("cdp without enhanced");
   AST_ROLE_FROZEN: assert property (
      $past(init_done_i) && $past(init_done_i, 2) && !$past(srst_i, 2) |-> $stable(port_role_o))
      else $error("port role changed after freeze");
   // dcp ports go dark one cycle later than host-managed ports
   AST_GANGED_OFF: assert property (
      ce_i && ganged_mode_i && $rose(|overcurrent_sense_i) |-> ##2 port_power_output_o == '0)
      else $error("ganged fault left a port powered");
   AST_FAULT_OFF: assert property (
      ce_i && !ganged_mode_i && $rose(overcurrent_sense_i[0]) |-> ##[1:2] !port_power_output_o[0])
      else $error("fault left port 1 powered");
   AST_HOST_POWER: assert property (
      ce_i && !ganged_mode_i && init_done_i && $past(init_done_i) && !$past(srst_i)
      && port_role_o[5:4] == ROLE_SDP |=> port_power_output_o[2] ==
      ($past(host_port_power_i[2]) && !$past(overcurrent_sense_i[2])))
      else $error("host port power not followed");
   AST_ACK_ROLE: assert property (
      charge_ack_o[0] == (port_role_o[1:0] != ROLE_SDP)) else $error("charge ack mismatch");
endmodule : cdpp_monitor

bind charger_detect_port_power cdpp_monitor #(
   .NPORTS(NPORTS), .SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) mon (.*);

// >>> sim/far_side_model.sv
// far side: charger line profile, device over-current and host port power
`timescale 1ns/1ps
module far_side_model
   import chg_pkg::*;
(
   // requests from the bench
   input  wire logic [2:0] kind_i,
   input  wire logic [2:0] fault_i,
   input  wire logic [2:0] hpwr_i,
   // lines toward the hub
   output logic [2:0]      line_profile_o,
   output logic [2:0]      overcurrent_sense_o,
   output logic [2:0]      host_port_power_o
);
   always_comb begin
      case (kind_i)
         TYPE_DCP:        line_profile_o = PROF_SHORTED;
         TYPE_CDP:        line_profile_o = PROF_REFLECT;
         TYPE_SDP:        line_profile_o = PROF_PULLDOWN;
         TYPE_PROP_LOW:   line_profile_o = PROF_P20_M20;
         TYPE_PROP_HIGH:  line_profile_o = PROF_P20_M27;
         TYPE_PROP_SUPER: line_profile_o = PROF_P27_M20;
         default:         line_profile_o = PROF_OPEN;
      endcase
   end
   assign overcurrent_sense_o = fault_i;
   assign host_port_power_o = hpwr_i;
endmodule : far_side_model

// >>> sim/charger_detect_port_power_tb.sv
// self-checking testbench for charger detection and port power
`timescale 1ns/1ps
module charger_detect_port_power_tb;
   import chg_pkg::*;
   localparam int SHORT = 20;
   localparam int LONG  = 50;
   logic       clk_i = 0, srst_i = 1, ce_i = 1, slave_serial_clock_pin_i = 1;
   logic       slave_serial_data_pin_i = 1, detect_enable_i = 0, enhanced_detect_setting_i = 1;
   logic       osc_detect_enable_i = 0, reference_clock_wait_stage_i = 0;
   logic       charger_detect_stage_i = 0, init_done_i = 0, host_connected_i = 0;
   logic       usb_cfg_we_i = 0, otp_cfg_valid_i = 0, reg_we_i = 0, reg_re_i = 0;
   logic       ganged_mode_i = 0, slave_enable_o, otp_prog_we_o, charger_irq_o;
   logic [2:0] charge_enable_strap_i = 0, line_profile_i, overcurrent_sense_i, host_port_power_i;
   logic [2:0] kind = 0, fault = 0, hpwr = 0, port_power_output_o, charge_ack_o, charger_type_o;
   logic [7:0] usb_cfg_data_i = 0, otp_cfg_data_i = 0, reg_addr_i = 0, reg_wdata_i = 0;
   logic [7:0] reg_rdata_o, otp_prog_data_o, custom_ctrl_o, d;
   logic [5:0] port_role_o;
   int         n_fail = 0, samples_checked = 0, n, e;
   logic [2:0] kinds [8] = '{TYPE_DCP, TYPE_CDP, TYPE_CDP, TYPE_SDP, TYPE_PROP_LOW,
                             TYPE_PROP_HIGH, TYPE_PROP_SUPER, TYPE_DCP};

   always #25 clk_i = ~clk_i;

   charger_detect_port_power #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut (.*);
   far_side_model far (.kind_i(kind), .fault_i(fault), .hpwr_i(hpwr),
      .line_profile_o(line_profile_i), .overcurrent_sense_o(overcurrent_sense_i),
      .host_port_power_o(host_port_power_i));

   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      {reg_addr_i, reg_wdata_i, reg_we_i} = {a, v, 1'b1};
      cyc(1);
      reg_we_i = 0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      {reg_addr_i, reg_re_i} = {a, 1'b1};
      cyc(1);
      reg_re_i = 0;
      v = reg_rdata_o;
   endtask : rd

   task automatic do_reset(input logic sd, input logic [2:0] strap, input logic enh);
      {srst_i, slave_serial_data_pin_i, enhanced_detect_setting_i} = {1'b1, sd, enh};
      charge_enable_strap_i = strap;
      {init_done_i, detect_enable_i, charger_detect_stage_i, ganged_mode_i} = 0;
      {osc_detect_enable_i, reference_clock_wait_stage_i, fault, hpwr} = 0;
      cyc(6);
      srst_i = 0;
      cyc(1);
   endtask : do_reset

   task automatic wait_pwr0(input logic v, output int k);
      for (k = 0; port_power_output_o[0] !== v && k < 200; k++) cyc(1);
   endtask : wait_pwr0

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      do_reset(0, 3'h0, 1);
      wr(REG_CUSTOM_CTRL, 8'ha5);
      chk("slave_enable", slave_enable_o, 0);
      chk("refused_write", custom_ctrl_o, 0);
      for (int i = 0; i < 8; i++) begin
         do_reset(1, 3'h0, i != 2);
         kind = kinds[i];
         {osc_detect_enable_i, reference_clock_wait_stage_i} = {2{i == 7}};
         {detect_enable_i, charger_detect_stage_i} = {1'b1, i != 7};
         for (n = 0; charger_irq_o !== 1'b1 && n < 40; n++) cyc(1);
         rd(REG_CHG_STATUS, d);
         chk("charger_status", d[3:0] == {1'b1, kinds[i]}, i != 2);
         chk("charger_type", charger_type_o, (i == 2) ? TYPE_SDP : kinds[i]);
         rd(REG_CHG_STATUS, d);
         chk("irq_cleared", {d[3], charger_irq_o}, 0);
      end
      do_reset(1, 3'h1, 1);
      rd(REG_CHG_EN, d);
      chk("strap_enable", d, 8'h02);
      {usb_cfg_data_i, usb_cfg_we_i} = {8'h04, 1'b1};
      cyc(1);
      usb_cfg_we_i = 0;
      rd(REG_CHG_EN, d);
      chk("usb_enable", d, 8'h04);
      wr(REG_CHG_EN, 8'h06);
      {hpwr, init_done_i} = {3'h4, 1'b1};
      cyc(3);
      wr(REG_CHG_EN, 8'h00);
      rd(REG_CHG_EN, d);
      chk("frozen_enable", d, 8'h06);
      chk("roles", port_role_o, {ROLE_SDP, ROLE_DCP, ROLE_DCP});
      chk("charge_ack", charge_ack_o, 3'h3);
      rd(REG_PORT_STATUS, d);
      chk("port_status", d, 8'h87);
      fault = 3'h4;
      cyc(2);
      chk("host_port_fault", port_power_output_o, 3'h3);
      fault = 3'h0;
      cyc(2);
      chk("host_port_back", port_power_output_o, 3'h7);
      fault = 3'h1;
      for (int i = 0; i < 6; i++) begin
         if (i == 5) begin
            // let the long off time run out and five clean powered cycles pass
            fault = 3'h0;
            cyc(LONG + 5);
            fault = 3'h1;
         end
         wait_pwr0(0, n);
         wait_pwr0(1, n);
         e = (i < 3 || i == 5) ? SHORT : LONG;
         chk("retry_off", n >= e - 1 && n <= e + 2, 1);
         chk("other_port_on", port_power_output_o[1], 1);
      end
      {fault, ganged_mode_i} = {3'h4, 1'b1};
      cyc(2);
      chk("ganged_off", port_power_output_o, 3'h0);
      fault = 3'h0;
      wr(REG_CUSTOM_CTRL, 8'h5a);
      chk("custom_ctrl", custom_ctrl_o, 8'h5a);
      {reg_addr_i, reg_wdata_i, reg_we_i} = {REG_OTP_DATA, 8'h3c, 1'b1};
      #1;
      chk("otp_strobe", {otp_prog_we_o, otp_prog_data_o[6:0]}, 8'hbc);
      cyc(1);
      reg_we_i = 0;
      do_reset(1, 3'h1, 1);
      {host_connected_i, init_done_i} = 2'b11;
      cyc(2);
      chk("cdp_role", port_role_o, {ROLE_SDP, ROLE_SDP, ROLE_CDP});
      rd(8'h7f, d);
      chk("unmapped", d, 8'h00);
      end_of_test();
   end

   initial begin
      repeat (5000) @(posedge clk_i);
      n_fail++;
      end_of_test();
   end
endmodule : charger_detect_port_power_tb
